//--- hw/ulm_line_modes.sv
/*
  line-mode logic of a serial port: infrared filter and modulator, bus driver
  direction, modem control and status, and the four channel routing modes,
  with registers on an avalon-mm slave with waitrequest.
  assumes a transmitter and receiver core on core_clk that supply bit, tick
  and empty indications; pins are asynchronous and pass three flip-flops.
*/
`timescale 1ns/1ns
// Contract
// RL1: software keeps infrared baud error within 1.87%
// RL2: infrared filter is 8-bit loadable down counter
// RL3: falling edge starts decrement each clock
// RL4: rising edge halts and reloads counter
// RL5: zero reached forces receiver low one bit
// RL6: software sets clock ratio nonzero before infrared
// RL7: mode code 0x1 selects bus driver mode
// RL8: bus mode drive equals inverse of empty
// RL9: drive stays high through timeguard period
// RL10: mode code 0x3 selects modem terminal mode
// RL11: modem mode forces asynchronous framing
// RL12: terminal-ready commands drive pin high or low
// RL13: modem mode drives request-to-send automatically
// RL14: modem input level change sets change flag
// RL15: status read clears the four change flags
// RL16: clear-to-send high disables transmitter after character
// RL17: normal route: pin to receiver, transmitter out
// RL18: echo route: input repeated out, receiver runs
// RL19: local loopback: transmitter to receiver, output high
// RL20: remote loopback: input to output, core disabled
// RL21: mode code 0x8 selects infrared mode
// RL22: infrared zero bit is three-sixteenths pulse
// RL23: two-bit route field selects channel routing
module ulm_line_modes (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rxd_pin,
  output logic txd_pin,
  output logic rts_pin,
  output logic dtr_pin,
  input wire logic cts_pin,
  input wire logic dsr_pin,
  input wire logic dcd_pin,
  input wire logic ri_pin,
  input wire logic core_tx_bit,
  input wire logic core_tx_bit_start,
  input wire logic core_tx_shifting,
  input wire logic core_tx_all_sent,
  input wire logic core_tg_busy,
  input wire logic core_x16_tick,
  output logic core_rx_bit,
  output logic core_rx_en,
  output logic core_tx_en,
  output logic core_sync_mode,
  output logic [7:0] core_timeguard,
  output logic [10:0] core_clock_ratio
);
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
    input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  ulm_ir_if ir ();

  logic ack_r;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic [31:0] wmask;
  logic [31:0] cmd;
  logic [31:0] mode_r;
  logic [10:0] ratio_r;
  logic [7:0] irf_r;
  logic [7:0] tg_r;
  logic tx_en_r;
  logic rx_en_r;
  logic dtr_r;
  logic rts_cmd_r;
  logic [3:0] chg_r;
  logic [3:0] chg_set;
  logic [3:0] chg_clr;
  logic [4:0] s1_r;
  logic [4:0] s2_r;
  logic [4:0] s3_r;
  logic [4:0] lvl_r;
  logic [4:0] lvl_nxt;
  logic [4:0] lvl_chg;
  logic [3:0] tick_r;
  logic [3:0] mode;
  ulm_pkg::ulm_route_t route;
  logic modem;
  logic ir_mode;
  logic tx_run;
  logic rx_run;
  logic ir_pulse;
  logic rx_src;
  logic txd_nxt;
  logic rx_nxt;
  logic rts_nxt;
  logic [31:0] rd_mux;

  localparam int MODE_POS = ulm_pkg::MODE_POS;
  localparam int ROUTE_POS = ulm_pkg::ROUTE_POS;
  assign mode = mode_r[MODE_POS+3:MODE_POS];
  assign route = ulm_pkg::ulm_route_t'(mode_r[ROUTE_POS+1:ROUTE_POS]); // RL23
  assign modem = (mode == ulm_pkg::MODE_MODEM); // RL10
  assign ir_mode = (mode == ulm_pkg::MODE_IR); // RL21

  // bus slave: one wait cycle; wait is held while ce is low so no access is lost
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_r & ce);
  assign acc = ce & ack_r & (avs_read | avs_write);
  assign wr_acc = acc & avs_write;
  assign rd_acc = acc & avs_read;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cmd = (wr_acc && avs_address == ulm_pkg::OFS_CMD) ? (avs_writedata & wmask) : '0;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else if (ce) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      ulm_pkg::OFS_MODE: rd_mux = mode_r;
      ulm_pkg::OFS_CSR: begin
        rd_mux[ulm_pkg::CSR_CHG_POS +: 4] = chg_r;
        rd_mux[ulm_pkg::CSR_LVL_POS +: 4] = lvl_r[4:1];
        rd_mux[ulm_pkg::CSR_ALL_SENT_POS] = core_tx_all_sent;
      end
      ulm_pkg::OFS_TG: rd_mux[7:0] = tg_r;
      ulm_pkg::OFS_RATIO: rd_mux[10:0] = ratio_r;
      ulm_pkg::OFS_IRF: rd_mux[7:0] = irf_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ce && avs_read && !ack_r) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= ulm_pkg::MODE_RST;
      ratio_r <= ulm_pkg::RATIO_RST;
      irf_r <= ulm_pkg::IRF_RST;
      tg_r <= ulm_pkg::TG_RST;
    end else if (wr_acc) begin
      case (avs_address)
        ulm_pkg::OFS_MODE: mode_r <= be_merge(mode_r, avs_writedata, avs_byteenable); // RL7
        ulm_pkg::OFS_RATIO: ratio_r <= 11'(be_merge({21'h0, ratio_r}, avs_writedata,
          avs_byteenable));
        ulm_pkg::OFS_IRF: irf_r <= 8'(be_merge({24'h0, irf_r}, avs_writedata,
          avs_byteenable)); // RL2
        ulm_pkg::OFS_TG: tg_r <= 8'(be_merge({24'h0, tg_r}, avs_writedata,
          avs_byteenable));
        default: ;
      endcase
    end
  end

  // a disable in the same write wins over the matching enable
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_en_r <= 1'b0;
      rx_en_r <= 1'b0;
      dtr_r <= 1'b1;
      rts_cmd_r <= 1'b1;
    end else if (ce) begin
      if (cmd[ulm_pkg::CMD_TXDIS]) tx_en_r <= 1'b0;
      else if (cmd[ulm_pkg::CMD_TXEN]) tx_en_r <= 1'b1;
      if (cmd[ulm_pkg::CMD_RXDIS]) rx_en_r <= 1'b0;
      else if (cmd[ulm_pkg::CMD_RXEN]) rx_en_r <= 1'b1;
      if (cmd[ulm_pkg::CMD_DTR_OFF]) dtr_r <= 1'b1; // RL12
      else if (cmd[ulm_pkg::CMD_DTR_ON]) dtr_r <= 1'b0; // RL12
      if (cmd[ulm_pkg::CMD_RTS_OFF]) rts_cmd_r <= 1'b1;
      else if (cmd[ulm_pkg::CMD_RTS_ON]) rts_cmd_r <= 1'b0;
    end
  end

  // pins {ri, dcd, dsr, cts, rxd}; a level counts once stages two and three agree
  assign lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r ^ s3_r));
  assign lvl_chg = lvl_nxt ^ lvl_r;
  assign chg_set = {lvl_chg[1], lvl_chg[3], lvl_chg[2], lvl_chg[4]}; // RL14
  assign chg_clr = rd_acc && avs_address == ulm_pkg::OFS_CSR ?
    avs_readdata[ulm_pkg::CSR_CHG_POS +: 4] : 4'h0; // RL15

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= ulm_pkg::PIN_RST;
      s2_r <= ulm_pkg::PIN_RST;
      s3_r <= ulm_pkg::PIN_RST;
      lvl_r <= ulm_pkg::PIN_RST;
    end else if (ce) begin
      s1_r <= {ri_pin, dcd_pin, dsr_pin, cts_pin, rxd_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  // only flags actually returned are cleared, so a new change is never lost
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      chg_r <= 4'h0;
    end else if (ce) begin
      chg_r <= (chg_r & ~chg_clr) | chg_set; // RL14 RL15
    end
  end

  // a character already in the shifter finishes before the stop applies
  assign tx_run = tx_en_r && route != ulm_pkg::ROUTE_REMOTE && // RL20
    !(modem && lvl_r[1] && !core_tx_shifting); // RL16
  assign rx_run = rx_en_r && route != ulm_pkg::ROUTE_REMOTE; // RL20

  // infrared modulator: pulse in the first three ticks of a zero bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_r <= 4'h0;
    end else if (ce) begin
      if (core_tx_bit_start) tick_r <= 4'h0;
      else if (core_x16_tick && tick_r != 4'hf) tick_r <= tick_r + 4'h1;
    end
  end
  assign ir_pulse = !core_tx_all_sent && !core_tx_bit &&
    ({1'b0, tick_r} < ulm_pkg::IR_PULSE_TICKS); // RL22

  assign ir.rx_level = lvl_r[0];
  assign ir.load_val = irf_r;
  assign ir.enable = ir_mode && rx_run;
  assign ir.x16_tick = core_x16_tick;
  assign rx_src = ir_mode ? ir.rx_out : lvl_r[0];

  always_comb begin
    case (route)
      ulm_pkg::ROUTE_NORMAL: begin
        txd_nxt = ir_mode ? ir_pulse : core_tx_bit; // RL17
        rx_nxt = rx_src; // RL17
      end
      ulm_pkg::ROUTE_ECHO: begin
        txd_nxt = lvl_r[0]; // RL18
        rx_nxt = rx_src; // RL18
      end
      ulm_pkg::ROUTE_LOCAL: begin
        txd_nxt = 1'b1; // RL19
        rx_nxt = core_tx_bit; // RL19
      end
      ulm_pkg::ROUTE_REMOTE: begin
        txd_nxt = lvl_r[0]; // RL20
        rx_nxt = 1'b1;
      end
      default: begin
        txd_nxt = 1'b1;
        rx_nxt = 1'b1;
      end
    endcase
  end

  always_comb begin
    case (mode)
      ulm_pkg::MODE_BUS: rts_nxt = !(core_tx_all_sent && !core_tg_busy); // RL8 RL9
      ulm_pkg::MODE_MODEM: rts_nxt = !tx_run; // RL13
      default: rts_nxt = rts_cmd_r;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txd_pin <= 1'b1;
      core_rx_bit <= 1'b1;
      rts_pin <= 1'b1;
      dtr_pin <= 1'b1;
      core_tx_en <= 1'b0;
      core_rx_en <= 1'b0;
      core_sync_mode <= 1'b0;
      core_timeguard <= ulm_pkg::TG_RST;
      core_clock_ratio <= ulm_pkg::RATIO_RST;
    end else if (ce) begin
      txd_pin <= txd_nxt;
      core_rx_bit <= rx_nxt;
      rts_pin <= rts_nxt;
      dtr_pin <= dtr_r;
      core_tx_en <= tx_run;
      core_rx_en <= rx_run;
      core_sync_mode <= mode_r[ulm_pkg::SYNC_POS] && !modem && !ir_mode; // RL11 RL21
      core_timeguard <= tg_r;
      core_clock_ratio <= ratio_r; // RL6
    end
  end

  ulm_ir_filter #(
    .FILT_W(8),
    .BIT_TICKS(ulm_pkg::BIT_TICKS)
  ) u_filt (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .ir(ir.filt)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_csr_read;
    rd_acc && avs_address == ulm_pkg::OFS_CSR && avs_readdata[ulm_pkg::CSR_CHG_POS +: 4] != 0;
  endsequence

  bus_rts_a: assert property (ce && mode == ulm_pkg::MODE_BUS |=> // RL8
    rts_pin == !($past(core_tx_all_sent) && !$past(core_tg_busy)))
    else $error("bus mode drive not inverse of empty");
  guard_rts_a: assert property (ce && mode == ulm_pkg::MODE_BUS && core_tg_busy // RL9
    |=> rts_pin)
    else $error("drive dropped during timeguard");
  dtr_cmd_a: assert property (ce && cmd[ulm_pkg::CMD_DTR_OFF] ##1 ce |=> dtr_pin) // RL12
    else $error("terminal ready not driven high");
  csr_clear_a: assert property (s_csr_read ##0 chg_set == 4'h0 |=> // RL15
    (chg_r & $past(avs_readdata[ulm_pkg::CSR_CHG_POS +: 4])) == 4'h0)
    else $error("change flags not cleared by read");
  chg_set_a: assert property (ce && lvl_chg[1] |=> chg_r[3]) // RL14
    else $error("clear-to-send change not flagged");
  local_idle_a: assert property (ce && route == ulm_pkg::ROUTE_LOCAL |=> txd_pin) // RL19
    else $error("output not idle in local loopback");
  remote_off_a: assert property (ce && route == ulm_pkg::ROUTE_REMOTE |=> // RL20
    !core_tx_en && !core_rx_en && txd_pin == $past(lvl_r[0]))
    else $error("remote loopback routing wrong");
  cts_hold_a: assert property (ce && modem && lvl_r[1] && !core_tx_shifting |=> // RL16
    !core_tx_en)
    else $error("transmitter not stopped by clear-to-send");
  echo_a: assert property (ce && route == ulm_pkg::ROUTE_ECHO |=> // RL18
    txd_pin == $past(lvl_r[0]))
    else $error("echo output does not follow input");
endmodule

//--- hw/ulm_pkg.sv
/*
  constants for the serial line-mode block: register offsets, field positions,
  reset values, mode codes and tick counts.
  assumes a 32-bit avalon-mm register bus with byte addresses.
*/
package ulm_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CSR = 8'h14;
  localparam logic [7:0] OFS_TG = 8'h28;
  localparam logic [7:0] OFS_RATIO = 8'h40;
  localparam logic [7:0] OFS_IRF = 8'h4c;

  localparam int MODE_POS = 0;
  localparam int SYNC_POS = 8;
  localparam int ROUTE_POS = 14;
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_BUS = 4'h1;
  localparam logic [3:0] MODE_MODEM = 4'h3;
  localparam logic [3:0] MODE_IR = 4'h8;

  localparam int CMD_RXEN = 4;
  localparam int CMD_RXDIS = 5;
  localparam int CMD_TXEN = 6;
  localparam int CMD_TXDIS = 7;
  localparam int CMD_DTR_ON = 16;
  localparam int CMD_DTR_OFF = 17;
  localparam int CMD_RTS_ON = 18;
  localparam int CMD_RTS_OFF = 19;

  localparam int CSR_ALL_SENT_POS = 9;
  localparam int CSR_CHG_POS = 16;
  localparam int CSR_LVL_POS = 20;

  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [10:0] RATIO_RST = 11'h174;
  localparam logic [7:0] IRF_RST = 8'h00;
  localparam logic [7:0] TG_RST = 8'h00;
  localparam logic [4:0] PIN_RST = 5'h1f;

  localparam int BIT_TICKS = 16;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;

  typedef enum logic [1:0] {
    ROUTE_NORMAL,
    ROUTE_ECHO,
    ROUTE_LOCAL,
    ROUTE_REMOTE
  } ulm_route_t;
endpackage

//--- hw/ulm_ir_if.sv
/*
  carrier between the line-mode top and its infrared receive filter.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
interface ulm_ir_if;
  logic rx_level;
  logic [7:0] load_val;
  logic enable;
  logic x16_tick;
  logic rx_out;
  modport top (output rx_level, output load_val, output enable, output x16_tick,
    input rx_out);
  modport filt (input rx_level, input load_val, input enable, input x16_tick,
    output rx_out);
endinterface

//--- hw/ulm_ir_filter.sv
/*
  infrared receive filter: a down counter qualifies a low pulse and then holds
  the receiver input low for one bit period.
  assumes rx_level is already synchronised and x16_tick is a one-cycle pulse.
*/
`timescale 1ns/1ns
module ulm_ir_filter #(
  parameter int FILT_W = 8,
  parameter int BIT_TICKS = ulm_pkg::BIT_TICKS
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  ulm_ir_if.filt ir
);
  typedef enum logic [1:0] {
    ULM_IDLE,
    ULM_COUNT,
    ULM_FORCE
  } ulm_filt_t;

  if (FILT_W != 8) begin : g_chk_w
    $error("filter counter must be 8 bits");
  end
  if (BIT_TICKS < 4 || BIT_TICKS > 31) begin : g_chk_t
    $error("bit ticks out of range");
  end

  localparam logic [4:0] TICK_LAST = 5'(BIT_TICKS - 1);

  ulm_filt_t state_r;
  logic [FILT_W-1:0] cnt_r;
  logic [4:0] tick_r;
  logic prev_r;
  logic fall;
  logic rise;

  assign fall = prev_r & ~ir.rx_level;
  assign rise = ~prev_r & ir.rx_level;
  assign ir.rx_out = (state_r != ULM_FORCE);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= 1'b1;
    end else if (ce) begin
      prev_r <= ir.rx_level;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ULM_IDLE;
      cnt_r <= '0;
      tick_r <= 5'h00;
    end else if (ce) begin
      if (!ir.enable) begin
        state_r <= ULM_IDLE;
        cnt_r <= ir.load_val;
      end else begin
        case (state_r)
          ULM_IDLE: begin
            cnt_r <= ir.load_val;
            if (fall) begin
              state_r <= ULM_COUNT; // RL3
            end
          end
          ULM_COUNT: begin
            if (rise) begin
              state_r <= ULM_IDLE; // RL4
              cnt_r <= ir.load_val;
            end else if (cnt_r == '0) begin
              state_r <= ULM_FORCE; // RL5
              tick_r <= 5'h00;
            end else begin
              cnt_r <= cnt_r - 1'b1; // RL2 RL3
            end
          end
          ULM_FORCE: begin
            // one bit is counted in receiver sample ticks, so it tracks the baud rate
            if (ir.x16_tick) begin
              if (tick_r == TICK_LAST) begin
                state_r <= ULM_IDLE; // RL5
                cnt_r <= ir.load_val;
              end else begin
                tick_r <= tick_r + 5'h01;
              end
            end
          end
          default: state_r <= ULM_IDLE;
        endcase
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_counting;
    ce && ir.enable && state_r == ULM_COUNT && !rise && cnt_r != '0;
  endsequence

  filt_decrement_a: assert property (s_counting |=> cnt_r == $past(cnt_r) - 1'b1) // RL3
    else $error("filter counter did not decrement");
  filt_reload_a: assert property (ce && ir.enable && state_r == ULM_COUNT && rise // RL4
    |=> state_r == ULM_IDLE && cnt_r == $past(ir.load_val))
    else $error("filter counter not reloaded on rising edge");
  filt_force_a: assert property (ce && ir.enable && state_r == ULM_COUNT && !rise // RL5
    && cnt_r == '0 |=> !ir.rx_out && tick_r == 5'h00)
    else $error("receiver input not forced low at zero");
endmodule

//--- dv/ulm_far_end.sv
/*
  far side of the serial line: a modem, bus driver or infrared transceiver
  that sets its lines to the levels that the bench asks for.
  assumes the bench changes line_req just after a rising edge.
*/
`timescale 1ns/1ns
module ulm_far_end (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [4:0] line_req,
  input wire logic txd_pin,
  input wire logic rts_pin,
  input wire logic dtr_pin,
  output logic rxd_pin,
  output logic ri_pin,
  output logic dsr_pin,
  output logic dcd_pin,
  output logic cts_pin
);
  // lines are idle high while the far end is in reset, so no change flag fires
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {cts_pin, dcd_pin, dsr_pin, ri_pin, rxd_pin} <= 5'h1f;
    end else begin
      {cts_pin, dcd_pin, dsr_pin, ri_pin, rxd_pin} <= line_req;
    end
  end
endmodule

//--- dv/ulm_line_modes_test.sv
/*
  self-checking bench for the line-mode block: registers over avalon-mm,
  routing, bus driver, modem and infrared behaviour at the pins.
  assumes the design package and a far-end model compiled before it.
*/
`timescale 1ns/1ns
module ulm_line_modes_test;
  typedef struct {logic [31:0] v; logic [31:0] m;} ulm_note_t;
  logic core_clk = 0, nrst = 0, ce = 1, avs_read = 0, avs_write = 0, pk = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, r;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, txd_pin, rts_pin, dtr_pin, rxd_pin, cts_pin, dsr_pin, dcd_pin;
  logic ri_pin, core_rx_bit, core_rx_en, core_tx_en, core_sync_mode, rb;
  logic core_tx_bit = 1, core_tx_bit_start = 0, core_tx_shifting = 0;
  logic core_tx_all_sent = 1, core_tg_busy = 0, core_x16_tick = 0;
  logic [4:0] line_req = 5'h1f;
  logic [7:0] core_timeguard;
  logic [10:0] core_clock_ratio;
  ulm_note_t notes[$];
  ulm_note_t n;
  int mismatches = 0, num_checks = 0;
  initial forever #20 core_clk = ~core_clk;
  always @(posedge core_clk) core_x16_tick <= ~core_x16_tick;
  ulm_line_modes u_ulm_line_modes (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .cts_pin(cts_pin),
    .dsr_pin(dsr_pin), .dcd_pin(dcd_pin), .ri_pin(ri_pin), .core_tx_bit(core_tx_bit),
    .core_tx_bit_start(core_tx_bit_start), .core_tx_shifting(core_tx_shifting),
    .core_tx_all_sent(core_tx_all_sent), .core_tg_busy(core_tg_busy),
    .core_x16_tick(core_x16_tick), .core_rx_bit(core_rx_bit), .core_rx_en(core_rx_en),
    .core_tx_en(core_tx_en), .core_sync_mode(core_sync_mode),
    .core_timeguard(core_timeguard), .core_clock_ratio(core_clock_ratio));
  ulm_far_end u_ulm_far_end (.core_clk(core_clk), .nrst(nrst), .line_req(line_req),
    .txd_pin(txd_pin), .rts_pin(rts_pin), .dtr_pin(dtr_pin), .rxd_pin(rxd_pin),
    .ri_pin(ri_pin), .dsr_pin(dsr_pin), .dcd_pin(dcd_pin), .cts_pin(cts_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // one request at a time, held until the edge where waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] be);
    int t;
    t = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (t >= 50) mismatches++;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    bus(0, a, 32'h0000_0000, 4'hf);
  endtask
  // pin vector: 0 txd, 1 rts, 2 dtr, 3 rx bit, 4 sync, 5 rx en, 6 tx en
  task automatic peek(input logic [31:0] v, input logic [31:0] m);
    notes.push_back('{v, m});
    @(posedge core_clk);
    pk <= 1;
    @(posedge core_clk);
    pk <= 0;
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // the watcher takes the oldest note whenever a read is accepted or a peek is due
  always @(negedge core_clk) begin
    if ((avs_read && avs_waitrequest === 1'b0) || pk) begin
      if (notes.size() == 0) begin
        mismatches++;
      end else begin
        n = notes.pop_front();
        if (pk) check({25'h0, core_tx_en, core_rx_en, core_sync_mode, core_rx_bit,
          dtr_pin, rts_pin, txd_pin} & n.m, n.v & n.m);
        else check(avs_readdata & n.m, n.v & n.m);
      end
    end
  end
  initial begin
    #(40 * 6000);
    mismatches++;
    summarize();
  end

  initial begin
    r = $urandom(32'h0244_aa2a);
    settle(2);
    nrst <= 1;
    rd(ulm_pkg::OFS_MODE, ulm_pkg::MODE_RST, 32'hffff_ffff);
    rd(ulm_pkg::OFS_RATIO, {21'h0, ulm_pkg::RATIO_RST}, 32'hffff_ffff);
    rd(ulm_pkg::OFS_IRF, {24'h0, ulm_pkg::IRF_RST}, 32'hffff_ffff);
    rd(ulm_pkg::OFS_TG, {24'h0, ulm_pkg::TG_RST}, 32'hffff_ffff);
    wr(8'h2c, $urandom);
    rd(8'h2c, 32'h0000_0000, 32'hffff_ffff);
    rd(ulm_pkg::OFS_CMD, 32'h0000_0000, 32'hffff_ffff);
    r = $urandom;
    wr(ulm_pkg::OFS_TG, r);
    rd(ulm_pkg::OFS_TG, r & 32'h0000_00ff, 32'hffff_ffff);
    wr(ulm_pkg::OFS_RATIO, r | 32'h0000_0001);
    rd(ulm_pkg::OFS_RATIO, (r | 32'h0000_0001) & 32'h0000_07ff, 32'hffff_ffff);
    // byte lane 1 only: the eight-bit filter value must not move
    bus(1, ulm_pkg::OFS_IRF, 32'h0000_5500, 4'h2);
    rd(ulm_pkg::OFS_IRF, 32'h0000_0000, 32'hffff_ffff);
    wr(ulm_pkg::OFS_CMD, 32'h0000_0050);
    for (int i = 0; i < 4; i++) begin
      rb = $urandom;
      wr(ulm_pkg::OFS_MODE, 32'(i) << ulm_pkg::ROUTE_POS);
      line_req[0] <= rb;
      core_tx_bit <= ~rb;
      settle(8);
      case (i)
        0: peek({25'h0, 2'b11, 1'b0, rb, 2'b0, ~rb}, 32'h0000_0069);
        1: peek({25'h0, 2'b11, 1'b0, rb, 2'b0, rb}, 32'h0000_0069);
        2: peek({25'h0, 2'b11, 1'b0, ~rb, 2'b0, 1'b1}, 32'h0000_0069);
        default: peek({25'h0, 2'b00, 4'h0, rb}, 32'h0000_0061);
      endcase
    end
    line_req[0] <= 1;
    wr(ulm_pkg::OFS_MODE, ulm_pkg::MODE_BUS);
    wr(ulm_pkg::OFS_CMD, 32'h0000_0050);
    for (int j = 0; j < 3; j++) begin
      core_tx_all_sent <= (j > 0);
      core_tg_busy <= (j == 2);
      settle(6);
      peek({30'h0, (j != 1), 1'b0}, 32'h0000_0002);
    end
    core_tg_busy <= 0;
    wr(ulm_pkg::OFS_MODE, ulm_pkg::MODE_MODEM | (32'h1 << ulm_pkg::SYNC_POS));
    settle(6);
    // clear-to-send is still inactive here, so the transmitter stays stopped
    peek(32'h0000_0002, 32'h0000_0052);
    for (int k = 0; k < 3; k++) begin
      wr(ulm_pkg::OFS_CMD, (k == 1) ? 32'h0001_0000 : (k == 0) ? 32'h0002_0000 : 32'h0003_0000);
      settle(3);
      peek({29'h0, (k != 1), 2'b0}, 32'h0000_0004);
    end
    rd(ulm_pkg::OFS_CSR, 32'h0000_0000, 32'h000f_0000);
    for (int k = 0; k < 4; k++) begin
      line_req[k + 1] <= 1'b0;
      settle(8);
      rd(ulm_pkg::OFS_CSR, 32'h1 << (16 + k), 32'h000f_0000);
      rd(ulm_pkg::OFS_CSR, 32'h0000_0000, 32'h000f_0000);
    end
    core_tx_shifting <= 1;
    line_req[4] <= 1;
    settle(8);
    peek(32'h0000_0040, 32'h0000_0042);
    core_tx_shifting <= 0;
    settle(8);
    peek(32'h0000_0002, 32'h0000_0042);
    wr(ulm_pkg::OFS_IRF, 32'h0000_0004);
    wr(ulm_pkg::OFS_MODE, ulm_pkg::MODE_IR);
    wr(ulm_pkg::OFS_CMD, 32'h0000_0050);
    core_tx_bit <= 1;
    core_tx_all_sent <= 0;
    settle(8);
    peek(32'h0000_0000, 32'h0000_0001);
    core_tx_bit <= 0;
    core_tx_bit_start <= 1;
    @(posedge core_clk);
    core_tx_bit_start <= 0;
    peek(32'h0000_0001, 32'h0000_0001);
    settle(10);
    peek(32'h0000_0000, 32'h0000_0001);
    core_tx_bit <= 1;
    // a pulse that passes the pin filter but is shorter than the filter load
    line_req[0] <= 0;
    settle(3);
    line_req[0] <= 1;
    for (int p = 0; p < 6; p++) peek(32'h0000_0008, 32'h0000_0008);
    line_req[0] <= 0;
    settle(12);
    line_req[0] <= 1;
    peek(32'h0000_0000, 32'h0000_0008);
    settle(12);
    peek(32'h0000_0000, 32'h0000_0008);
    settle(24);
    peek(32'h0000_0008, 32'h0000_0008);
    // divisor choice lies with software; no baud divisor lives in this block
    summarize();
  end
endmodule
